// ===== hdl/ibs_pkg.sv
// package: constants and carrier types of the bus-cycle sequencer
package ibs_pkg;
    localparam logic [15:0] IDLE_ADDR = 16'hFFFF; // dummy-cycle address
    localparam logic [7:0] ZERO_PAGE = 8'h00; // direct-mode high byte
    localparam logic [15:0] RESET_PC = 16'h0000; // first opcode address
    localparam logic [7:0] PFX_Y = 8'h18; // page-select prefix, Y page
    localparam logic [7:0] PFX_D = 8'h1A; // page-select prefix, D compare
    localparam logic [7:0] OP_LDY_IMM = 8'hEC;
    localparam logic [7:0] OP_LDY_DIR = 8'hDE;
    localparam logic [7:0] OP_STY_DIR = 8'hDF;
    localparam logic [7:0] OP_CPY_IMM = 8'h8C;
    localparam logic [7:0] OP_CPY_DIR = 8'h9C;
    localparam logic [7:0] OP_CPD_IMM = 8'h83;
    localparam logic [7:0] OP_CPD_DIR = 8'h93;
    // low-nibble groups of unprefixed opcodes, plus one high nibble
    localparam logic [3:0] LO_ACC_MAX = 4'hB;
    localparam logic [3:0] LO_ALU16 = 4'h3;
    localparam logic [3:0] LO_STA8 = 4'h7;
    localparam logic [3:0] LO_CPX_LDD = 4'hC;
    localparam logic [3:0] LO_STD = 4'hD;
    localparam logic [3:0] LO_LDSX = 4'hE;
    localparam logic [3:0] LO_STSX = 4'hF;
    localparam logic [3:0] HI_DIR_B = 4'hD;

    typedef enum logic [2:0] {SRC_A, SRC_B, SRC_D, SRC_S, SRC_X, SRC_Y} ibs_src_t;

    typedef enum {ST_OPC, ST_OPC2, ST_DADR, ST_RDHI, ST_RDLO, ST_WRHI, ST_WRLO, ST_DUMMY} ibs_state_t;

    // decoded instruction group
    typedef struct packed {
        logic ok;
        logic dir;
        logic wide;
        logic dummy;
        logic store;
        ibs_src_t src;
    } ibs_dec_t;

    // core register values offered for stores
    typedef struct packed {
        logic [7:0] accA;
        logic [7:0] accB;
        logic [15:0] sp;
        logic [15:0] ix;
        logic [15:0] iy;
    } ibs_regs_t;

    // external bus drive
    typedef struct packed {
        logic [15:0] addr;
        logic rnw;
        logic [7:0] wdata;
    } ibs_bus_t;
endpackage

// ===== hdl/ibs_sequencer.sv
// module: immediate and direct mode bus-cycle sequencer
// Operation
// - immediate 8-bit ops: opcode, operand, 2 cycles
// - immediate 16-bit loads: opcode, high, low
// - immediate 16-bit alu: three reads plus dummy
// - immediate Y load: prefix, opcode, high, low
// - immediate D/Y compare: four reads plus dummy
// - direct mode: high address byte forced zero
// - direct 8-bit ops: opcode, address, operand
// - direct 16-bit loads: high then low byte
// - direct stores drive write low on data
// - direct Y load: five read cycles
// - direct Y store: three reads, two writes
`timescale 1ns/100ps
module ibs_sequencer
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] dataIn,
    input wire ibs_pkg::ibs_regs_t regsIn,
    output ibs_pkg::ibs_bus_t busOut,
    output logic instDone,
    output logic [7:0] instOpcode,
    output logic [15:0] instOperand
);
    // whole state of the sequencer
    typedef struct packed {
        ibs_pkg::ibs_state_t st;
        ibs_pkg::ibs_bus_t bus;
        logic [15:0] pc;
        logic [7:0] page;
        logic [7:0] op;
        ibs_pkg::ibs_dec_t dec;
        logic [15:0] operand;
        logic [15:0] wword;
        logic done;
    } ibs_seq_t;

    ibs_seq_t s_q;
    ibs_seq_t s_d;
    ibs_pkg::ibs_dec_t decNow;

    function automatic logic [15:0] inc16(input logic [15:0] a);
        inc16 = a + 16'h0001;
    endfunction

    // opcode to cycle-group decode
    function automatic ibs_pkg::ibs_dec_t decode(input logic [7:0] page, input logic [7:0] op);
        ibs_pkg::ibs_dec_t d;
        logic [3:0] lo;
        logic [3:0] hi;
        d = '0;
        lo = op[3:0];
        hi = op[7:4];
        if (page == ibs_pkg::PFX_Y)
        begin
            if (op == ibs_pkg::OP_CPY_IMM || op == ibs_pkg::OP_CPY_DIR)
            begin
                d.ok = 1'b1;
                d.dir = op[4];
                d.wide = 1'b1;
                d.dummy = 1'b1;
            end
            else if (op == ibs_pkg::OP_LDY_IMM || op == ibs_pkg::OP_LDY_DIR)
            begin
                d.ok = 1'b1;
                d.dir = (op == ibs_pkg::OP_LDY_DIR);
                d.wide = 1'b1;
            end
            else if (op == ibs_pkg::OP_STY_DIR)
            begin
                d.ok = 1'b1;
                d.dir = 1'b1;
                d.wide = 1'b1;
                d.store = 1'b1;
                d.src = ibs_pkg::SRC_Y;
            end
        end
        else if (page == ibs_pkg::PFX_D)
        begin
            if (op == ibs_pkg::OP_CPD_IMM || op == ibs_pkg::OP_CPD_DIR)
            begin
                d.ok = 1'b1;
                d.dir = op[4];
                d.wide = 1'b1;
                d.dummy = 1'b1;
            end
        end
        else if (hi[3] && !hi[1])
        begin
            d.dir = hi[0];
            d.src = hi[2] ? ibs_pkg::SRC_B : ibs_pkg::SRC_A;
            if (lo == ibs_pkg::LO_ALU16 || (lo == ibs_pkg::LO_CPX_LDD && !hi[2]))
            begin
                d.ok = 1'b1;
                d.wide = 1'b1;
                d.dummy = 1'b1;
            end
            else if (lo == ibs_pkg::LO_STA8)
            begin
                d.ok = hi[0];
                d.store = 1'b1;
            end
            else if (lo <= ibs_pkg::LO_ACC_MAX)
            begin
                d.ok = 1'b1;
            end
            else if (lo == ibs_pkg::LO_CPX_LDD || lo == ibs_pkg::LO_LDSX)
            begin
                d.ok = 1'b1;
                d.wide = 1'b1;
            end
            else if (lo == ibs_pkg::LO_STD)
            begin
                d.ok = (hi == ibs_pkg::HI_DIR_B);
                d.wide = 1'b1;
                d.store = 1'b1;
                d.src = ibs_pkg::SRC_D;
            end
            else if (lo == ibs_pkg::LO_STSX)
            begin
                d.ok = hi[0];
                d.wide = 1'b1;
                d.store = 1'b1;
                d.src = hi[2] ? ibs_pkg::SRC_X : ibs_pkg::SRC_S;
            end
        end
        decode = d;
    endfunction

    // value a store puts on the bus, high byte first
    function automatic logic [15:0] storeWord(input ibs_pkg::ibs_src_t src, input ibs_pkg::ibs_regs_t r);
        case (src)
            ibs_pkg::SRC_A: storeWord = {r.accA, r.accA};
            ibs_pkg::SRC_B: storeWord = {r.accB, r.accB};
            ibs_pkg::SRC_D: storeWord = {r.accA, r.accB};
            ibs_pkg::SRC_S: storeWord = r.sp;
            ibs_pkg::SRC_X: storeWord = r.ix;
            default: storeWord = r.iy;
        endcase
    endfunction

    // decode of the byte fetched in the current cycle
    always_comb
    begin
        decNow = decode(s_q.st == ibs_pkg::ST_OPC2 ? s_q.page : 8'h00, dataIn);
    end

    // next-state and next-bus logic
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.bus.rnw = 1'b1;
        case (s_q.st)
            ibs_pkg::ST_OPC, ibs_pkg::ST_OPC2:
            begin
                s_d.pc = inc16(s_q.bus.addr);
                s_d.bus.addr = s_d.pc;
                s_d.op = dataIn;
                s_d.dec = decNow;
                s_d.operand = '0;
                s_d.wword = storeWord(decNow.src, regsIn);
                if (s_q.st == ibs_pkg::ST_OPC && (dataIn == ibs_pkg::PFX_Y || dataIn == ibs_pkg::PFX_D))
                begin
                    s_d.page = dataIn;
                    s_d.st = ibs_pkg::ST_OPC2;
                end
                else if (!decNow.ok)
                begin
                    s_d.st = ibs_pkg::ST_OPC;
                    s_d.done = 1'b1;
                end
                else if (decNow.dir)
                begin
                    s_d.st = ibs_pkg::ST_DADR;
                end
                else
                begin
                    s_d.st = decNow.wide ? ibs_pkg::ST_RDHI : ibs_pkg::ST_RDLO;
                end
                if (s_q.st == ibs_pkg::ST_OPC2)
                begin
                    s_d.page = '0;
                end
            end
            ibs_pkg::ST_DADR:
            begin
                s_d.pc = inc16(s_q.bus.addr);
                s_d.bus.addr = {ibs_pkg::ZERO_PAGE, dataIn};
                if (s_q.dec.store)
                begin
                    s_d.bus.rnw = 1'b0;
                    s_d.st = s_q.dec.wide ? ibs_pkg::ST_WRHI : ibs_pkg::ST_WRLO;
                    s_d.bus.wdata = s_q.dec.wide ? s_q.wword[15:8] : s_q.wword[7:0];
                end
                else
                begin
                    s_d.st = s_q.dec.wide ? ibs_pkg::ST_RDHI : ibs_pkg::ST_RDLO;
                end
            end
            ibs_pkg::ST_RDHI:
            begin
                s_d.operand[15:8] = dataIn;
                if (!s_q.dec.dir)
                begin
                    s_d.pc = inc16(s_q.bus.addr);
                end
                s_d.bus.addr = inc16(s_q.bus.addr);
                s_d.st = ibs_pkg::ST_RDLO;
            end
            ibs_pkg::ST_WRHI:
            begin
                s_d.bus.addr = inc16(s_q.bus.addr);
                s_d.bus.rnw = 1'b0;
                s_d.bus.wdata = s_q.wword[7:0];
                s_d.st = ibs_pkg::ST_WRLO;
            end
            default:
            begin
                if (s_q.st == ibs_pkg::ST_RDLO)
                begin
                    s_d.operand[7:0] = dataIn;
                    if (!s_q.dec.dir)
                    begin
                        s_d.pc = inc16(s_q.bus.addr);
                    end
                end
                if (s_q.st == ibs_pkg::ST_RDLO && s_q.dec.dummy)
                begin
                    s_d.bus.addr = ibs_pkg::IDLE_ADDR;
                    s_d.st = ibs_pkg::ST_DUMMY;
                end
                else
                begin
                    s_d.bus.addr = s_d.pc;
                    s_d.st = ibs_pkg::ST_OPC;
                    s_d.done = 1'b1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.st <= ibs_pkg::ST_OPC;
            s_q.bus.addr <= ibs_pkg::RESET_PC;
            s_q.bus.rnw <= 1'b1;
            s_q.pc <= ibs_pkg::RESET_PC;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign busOut = s_q.bus;
    assign instDone = s_q.done;
    assign instOpcode = s_q.op;
    assign instOperand = s_q.operand;

    // cycle sequences used by the checks
    sequence seqImm8;
        s_q.st == ibs_pkg::ST_OPC && decNow.ok && !decNow.dir && !decNow.wide && !decNow.store;
    endsequence
    sequence seqImmLd16;
        s_q.st == ibs_pkg::ST_OPC && dataIn != ibs_pkg::PFX_Y && dataIn != ibs_pkg::PFX_D
            && decNow.ok && !decNow.dir && decNow.wide && !decNow.dummy;
    endsequence
    sequence seqDirFetch;
        s_q.st == ibs_pkg::ST_DADR && !s_q.dec.store;
    endsequence

    chk_imm8_len: assert property (@(posedge clock) disable iff (rst)
        seqImm8 |=> s_q.st == ibs_pkg::ST_RDLO && s_q.bus.addr == inc16($past(s_q.bus.addr))
            ##1 s_q.st == ibs_pkg::ST_OPC && instDone)
        else $error("immediate 8-bit op not two cycles");
    chk_imm16_len: assert property (@(posedge clock) disable iff (rst)
        seqImmLd16 |=> s_q.st == ibs_pkg::ST_RDHI ##1 s_q.st == ibs_pkg::ST_RDLO ##1 instDone)
        else $error("immediate 16-bit load not three cycles");
    chk_dummy_addr: assert property (@(posedge clock) disable iff (rst)
        s_q.st == ibs_pkg::ST_DUMMY |-> s_q.bus.addr == ibs_pkg::IDLE_ADDR && s_q.bus.rnw ##1 instDone)
        else $error("dummy cycle not at all-ones read");
    chk_ldy_imm: assert property (@(posedge clock) disable iff (rst)
        s_q.st == ibs_pkg::ST_OPC2 && s_q.page == ibs_pkg::PFX_Y && dataIn == ibs_pkg::OP_LDY_IMM
            |=> s_q.st == ibs_pkg::ST_RDHI ##1 s_q.st == ibs_pkg::ST_RDLO ##1 instDone)
        else $error("immediate Y load sequence wrong");
    chk_cmp_dummy: assert property (@(posedge clock) disable iff (rst)
        s_q.st == ibs_pkg::ST_RDLO && s_q.dec.dummy |=> s_q.st == ibs_pkg::ST_DUMMY ##1 instDone)
        else $error("compare lacks dummy cycle");
    chk_zero_page: assert property (@(posedge clock) disable iff (rst)
        s_q.st == ibs_pkg::ST_DADR |=> s_q.bus.addr == {ibs_pkg::ZERO_PAGE, $past(dataIn)})
        else $error("direct address high byte not zero");
    chk_dir_read: assert property (@(posedge clock) disable iff (rst)
        seqDirFetch |=> (s_q.bus.rnw && s_q.st == ibs_pkg::ST_RDLO)
            or (s_q.bus.rnw && s_q.st == ibs_pkg::ST_RDHI ##1 s_q.bus.addr == inc16($past(s_q.bus.addr))))
        else $error("direct read sequence wrong");
    chk_store_low: assert property (@(posedge clock) disable iff (rst)
        !s_q.bus.rnw |-> s_q.st == ibs_pkg::ST_WRHI || s_q.st == ibs_pkg::ST_WRLO)
        else $error("write outside a store data cycle");
    chk_store_pair: assert property (@(posedge clock) disable iff (rst)
        s_q.st == ibs_pkg::ST_WRHI |=> !s_q.bus.rnw && s_q.bus.addr == inc16($past(s_q.bus.addr))
            && s_q.bus.wdata == $past(s_q.wword[7:0]) ##1 instDone)
        else $error("16-bit store pair wrong");
    chk_next_fetch: assert property (@(posedge clock) disable iff (rst)
        instDone |-> s_q.st == ibs_pkg::ST_OPC && s_q.bus.rnw && s_q.bus.addr == s_q.pc)
        else $error("next opcode fetch misplaced");
endmodule // ibs_sequencer

// ===== tb/ibs_mem_model.sv
// partner: byte-wide program and data memory on the sequencer bus
`timescale 1ns/100ps
module ibs_mem_model
(
    input wire logic clock,
    input wire ibs_pkg::ibs_bus_t busIn,
    output logic [7:0] dataOut
);
    logic [7:0] mem [65536];
    logic [7:0] lastRead_q;

    // same-cycle read answer, inverse of last byte while not reading
    always_comb
    begin
        dataOut = busIn.rnw ? mem[busIn.addr] : ~lastRead_q;
    end

    // write capture and last-read history
    always @(posedge clock)
    begin
        if (busIn.rnw)
        begin
            lastRead_q <= mem[busIn.addr];
        end
        else
        begin
            mem[busIn.addr] <= busIn.wdata;
        end
    end
endmodule // ibs_mem_model

// ===== tb/test_imm_direct_bus_cycle_sequencer.sv
// testbench: table-driven and random instruction streams against the sequencer
`timescale 1ns/100ps
module test_imm_direct_bus_cycle_sequencer;
    // entry: prefix, opcode, direct, data bytes, store source, dummy cycle
    localparam int NT = 30;
    localparam logic [31:0] TBL [NT] = '{
        32'h00860100, 32'h008B0100, 32'h00840100, 32'h00C90100, 32'h00CC0200, 32'h008E0200, 32'h00CE0200,
        32'h00C30201, 32'h00830201, 32'h008C0201, 32'h18EC0200, 32'h1A830201, 32'h188C0201, 32'h00961100,
        32'h00D91100, 32'h00971110, 32'h00D71120, 32'h00DC1200, 32'h009E1200, 32'h00DE1200, 32'h00DD1230,
        32'h009F1240, 32'h00DF1250, 32'h18DE1200, 32'h18DF1260, 32'h00D31201, 32'h00010000, 32'h18010000,
        32'h1A931201, 32'h189C1201};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] dataIn;
    ibs_pkg::ibs_regs_t regsIn = '0;
    ibs_pkg::ibs_bus_t busOut;
    logic instDone;
    logic [7:0] instOpcode;
    logic [15:0] instOperand;
    logic [7:0] shad [65536];
    logic [15:0] pc;
    logic [15:0] wp;
    logic first;
    logic [7:0] lastOp;
    logic [15:0] lastOpnd;
    int errCount = 0;
    int checked = 0;
    int seed = 32'h454B;
    int k;

    // clock generation
    always #25 clock = ~clock;

    ibs_sequencer dut_u (.clock(clock), .rst(rst), .dataIn(dataIn), .regsIn(regsIn), .busOut(busOut),
        .instDone(instDone), .instOpcode(instOpcode), .instOperand(instOperand));
    ibs_mem_model mem_u (.clock(clock), .busIn(busOut), .dataOut(dataIn));

    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d, errors %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errCount++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmpBit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errCount++;
            $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // opcode and operand of the finished instruction, looked at in its done cycle
    task automatic cmpLast();
        cmpWord({8'h00, instOpcode}, {8'h00, lastOp}, "opcode");
        cmpWord(instOperand, lastOpnd, "operand");
    endtask

    // one bus cycle: check it now, move the register inputs, step to next falling edge
    task automatic cyc(input logic [15:0] a, input logic rd, input logic [7:0] wd, input logic dn);
        cmpWord(busOut.addr, a, "address");
        cmpBit(busOut.rnw, rd, "read line");
        cmpBit(instDone, dn, "done pulse");
        if (!rd)
        begin
            cmpWord({8'h00, busOut.wdata}, {8'h00, wd}, "write data");
            shad[a] = wd;
        end
        regsIn = {$random(seed), $random(seed)};
        @(negedge clock);
    endtask

    task automatic put(input logic [7:0] b);
        mem_u.mem[wp] = b;
        shad[wp] = b;
        wp++;
    endtask

    function automatic logic [15:0] srcVal(input ibs_pkg::ibs_regs_t r, input logic [3:0] s);
        case (s)
            4'h1: return {8'h00, r.accA};
            4'h2: return {8'h00, r.accB};
            4'h3: return {r.accA, r.accB};
            4'h4: return r.sp;
            4'h5: return r.ix;
            default: return r.iy;
        endcase
    endfunction

    // place one instruction at pc and walk its expected bus cycles
    task automatic walk(input logic [31:0] e, input int i);
        logic [15:0] ea;
        logic [15:0] val;
        logic [15:0] opnd;
        logic [7:0] b;
        int n;
        n = e[11:8];
        opnd = '0;
        wp = pc;
        if (e[31:24] != 8'h00)
        begin
            put(e[31:24]);
        end
        put(e[23:16]);
        if (e[15:12] != 4'h0)
        begin
            put((i % 5 == 0) ? 8'hFF : (8'h80 | 8'($random(seed))));
        end
        else
        begin
            repeat (n) put(8'($random(seed)));
        end
        // previous results stand only during this fetch cycle
        if (!first)
        begin
            cmpLast();
        end
        cyc(pc, 1'b1, 8'h00, !first);
        first = 1'b0;
        pc++;
        if (e[31:24] != 8'h00)
        begin
            cyc(pc, 1'b1, 8'h00, 1'b0);
            pc++;
        end
        val = srcVal(regsIn, e[7:4]);
        ea = pc;
        if (e[15:12] != 4'h0)
        begin
            cyc(pc, 1'b1, 8'h00, 1'b0);
            ea = {ibs_pkg::ZERO_PAGE, shad[pc]};
            pc++;
        end
        for (int j = 0; j < n; j++)
        begin
            b = (n == 2 && j == 0) ? val[15:8] : val[7:0];
            if (e[7:4] != 4'h0)
            begin
                cyc(ea + 16'(j), 1'b0, b, 1'b0);
            end
            else
            begin
                opnd = {opnd[7:0], shad[ea + 16'(j)]};
                cyc(ea + 16'(j), 1'b1, 8'h00, 1'b0);
            end
        end
        if (e[15:12] == 4'h0)
        begin
            pc = pc + 16'(n);
        end
        if (e[3:0] != 4'h0)
        begin
            cyc(ibs_pkg::IDLE_ADDR, 1'b1, 8'h00, 1'b0);
        end
        lastOp = e[23:16];
        lastOpnd = opnd;
    endtask

    // main sequence: every table entry once, then random mix, reset between runs
    initial
    begin
        for (int a = 0; a < 65536; a++)
        begin
            mem_u.mem[a] = 8'($random(seed));
            shad[a] = mem_u.mem[a];
        end
        for (int r = 0; r < 6; r++)
        begin
            @(negedge clock);
            rst = 1'b1;
            repeat ((r == 0) ? 6 : 2) @(negedge clock);
            rst = 1'b0;
            pc = ibs_pkg::RESET_PC;
            first = 1'b1;
            for (int i = 0; i < 20; i++)
            begin
                k = r * 20 + i;
                walk((k < NT) ? TBL[k] : TBL[$unsigned($random(seed)) % NT], i);
            end
            // last instruction of the run, still in its done cycle
            cmpBit(instDone, 1'b1, "done pulse");
            cmpWord(busOut.addr, pc, "address");
            cmpLast();
        end
        report_and_stop();
    end

    // watchdog against a stalled run
    initial
    begin
        repeat (20000) @(posedge clock);
        errCount++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // test_imm_direct_bus_cycle_sequencer
